// *** shared/psm_pkg.sv ***
// Package of constants for the power-save mode controller
package psm_pkg;

  // AXI4-Lite register byte offsets
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] PMD_OFFSET    = 8'h08;
  localparam logic [7:0] SIDL_OFFSET   = 8'h0C;

  // Control register fields (regulator keep-on bits as in the reset control register)
  localparam int WDT_EN_BIT    = 0;
  localparam int CFM_EN_BIT    = 1;
  localparam int CORE_KEEP_BIT = 8;
  localparam int FLASH_KEEP_BIT = 11;

  // Timer one control stop-in-idle position
  localparam int TIMER_SIDL_BIT = 13;

  localparam int NUM_PERIPH = 8;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [NUM_PERIPH-1:0] PMD_RESET  = 8'h00;
  localparam logic [NUM_PERIPH-1:0] SIDL_RESET = 8'h00;

  // Cycles from wake to CPU clock and on to execution (2..4 allowed)
  localparam int WAKE_EXEC_CYCLES = 3;
  localparam logic [1:0] WAKE_COUNT_INIT = 2'h2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PSM_RUN, PSM_ENTER_SLEEP, PSM_SLEEP, PSM_ENTER_IDLE, PSM_IDLE, PSM_WAKE
  } psm_state_t;

endpackage

// *** rtl/psm_power_save_mode_control.sv ***
// Power-save mode controller: Sleep/Idle entry, gating and wake-up
`timescale 1ns/1ps
module psm_power_save_mode_control (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Power-save requests from the core, wake events and clock source select
  input  wire logic        sleep_req_i,
  input  wire logic        idle_req_i,
  input  wire logic        irq_pending_i,
  input  wire logic        wdt_timeout_i,
  input  wire logic [1:0]  clk_source_sel_i,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Power and clock controls
  output logic             sys_clk_en_o,
  output logic             osc_en_o,
  output logic             cpu_clk_en_o,
  output logic             cpu_exec_o,
  output logic             cfm_active_o,
  output logic             low_power_rc_clock_en_o,
  output logic             wdt_clear_o,
  output logic             core_reg_standby_o,
  output logic             flash_reg_standby_o,
  output logic             pin_change_en_o,
  output logic             ext_clk_periph_en_o,
  output logic [1:0]       resume_clk_source_o,
  output logic [7:0]       periph_clk_en_o,
  output logic             in_sleep_o,
  output logic             in_idle_o
);

  psm_pkg::psm_state_t state;
  psm_pkg::psm_state_t next_state;
  logic [31:0]         ctrl;
  logic [7:0]          pmd;
  logic [7:0]          sidl;
  logic [1:0]          wake_cnt;
  logic                held_irq;
  logic                aw_hold;
  logic                w_hold;
  logic [7:0]          aw_addr;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;

  // Control bits that software may set; all others read as zero
  localparam logic [31:0] CTRL_WRITABLE = (32'h0000_0001 << psm_pkg::WDT_EN_BIT) |
                                          (32'h0000_0001 << psm_pkg::CFM_EN_BIT) |
                                          (32'h0000_0001 << psm_pkg::CORE_KEEP_BIT) |
                                          (32'h0000_0001 << psm_pkg::FLASH_KEEP_BIT);

  // Merges a write onto a register honouring byte strobes
  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // True in the single cycle that moves the mode towards Sleep or Idle
  function automatic logic is_entry(input psm_pkg::psm_state_t s);
    return (s == psm_pkg::PSM_ENTER_SLEEP) || (s == psm_pkg::PSM_ENTER_IDLE);
  endfunction

  // Control fields and the combined wake request
  wire logic wdt_en    = ctrl[psm_pkg::WDT_EN_BIT];
  wire logic cfm_en    = ctrl[psm_pkg::CFM_EN_BIT];
  wire logic wake_evt  = irq_pending_i | wdt_timeout_i | held_irq;

  // Mode sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      psm_pkg::PSM_RUN: begin
        if (sleep_req_i) begin
          next_state = psm_pkg::PSM_ENTER_SLEEP;
        end else if (idle_req_i) begin
          next_state = psm_pkg::PSM_ENTER_IDLE;
        end
      end
      psm_pkg::PSM_ENTER_SLEEP: next_state = psm_pkg::PSM_SLEEP;
      psm_pkg::PSM_ENTER_IDLE:  next_state = psm_pkg::PSM_IDLE;
      psm_pkg::PSM_SLEEP, psm_pkg::PSM_IDLE: begin
        if (wake_evt) begin
          next_state = psm_pkg::PSM_WAKE;
        end
      end
      psm_pkg::PSM_WAKE: begin
        if (wake_cnt == 2'h0) begin
          next_state = psm_pkg::PSM_RUN;
        end
      end
      default: next_state = psm_pkg::PSM_RUN;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= psm_pkg::PSM_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Interrupts arriving during entry are held until the Wake state clears them
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      held_irq <= 1'b0;
    end else if (is_entry(state)) begin
      held_irq <= held_irq | irq_pending_i | wdt_timeout_i;
    end else if (state == psm_pkg::PSM_WAKE) begin
      held_irq <= 1'b0;
    end
  end

  // Counts the CPU clock cycles that precede execution after a wake
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_cnt <= 2'h0;
    end else if (next_state == psm_pkg::PSM_WAKE && state != psm_pkg::PSM_WAKE) begin
      wake_cnt <= psm_pkg::WAKE_COUNT_INIT;
    end else if (wake_cnt != 2'h0) begin
      wake_cnt <= wake_cnt - 2'h1;
    end
  end

  // Sleep-entry clock source capture for resumption
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      resume_clk_source_o <= 2'h0;
    end else if (state == psm_pkg::PSM_RUN && sleep_req_i) begin
      resume_clk_source_o <= clk_source_sel_i;
    end
  end

  // Mode flags mirror the state register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_sleep_o <= 1'b0;
      in_idle_o  <= 1'b0;
    end else begin
      in_sleep_o <= (next_state == psm_pkg::PSM_SLEEP);
      in_idle_o  <= (next_state == psm_pkg::PSM_IDLE);
    end
  end

  // System clock, oscillator and CPU gating
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sys_clk_en_o <= 1'b1;
      osc_en_o     <= 1'b1;
      cpu_clk_en_o <= 1'b1;
      cpu_exec_o   <= 1'b1;
    end else begin
      sys_clk_en_o <= (next_state != psm_pkg::PSM_SLEEP);
      osc_en_o     <= (next_state != psm_pkg::PSM_SLEEP);
      // CPU clock back three cycles before execution starts
      cpu_clk_en_o <= (next_state == psm_pkg::PSM_RUN) ||
                      (next_state == psm_pkg::PSM_WAKE);
      cpu_exec_o   <= (next_state == psm_pkg::PSM_RUN);
    end
  end

  // Clock failure monitor, low-power RC and watchdog clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfm_active_o <= 1'b0;
      low_power_rc_clock_en_o    <= 1'b0;
      wdt_clear_o  <= 1'b0;
    end else begin
      cfm_active_o <= cfm_en && (next_state != psm_pkg::PSM_SLEEP);
      if (next_state == psm_pkg::PSM_SLEEP) begin
        low_power_rc_clock_en_o <= wdt_en;
      end else begin
        low_power_rc_clock_en_o <= wdt_en | cfm_en;
      end
      wdt_clear_o  <= wdt_en && is_entry(next_state);
    end
  end

  // Regulators go to standby in Sleep unless kept on
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_reg_standby_o  <= 1'b0;
      flash_reg_standby_o <= 1'b0;
    end else begin
      core_reg_standby_o  <= (next_state == psm_pkg::PSM_SLEEP) &&
                             !ctrl[psm_pkg::CORE_KEEP_BIT];
      flash_reg_standby_o <= (next_state == psm_pkg::PSM_SLEEP) &&
                             !ctrl[psm_pkg::FLASH_KEEP_BIT];
    end
  end

  // Peripheral clock enables
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_change_en_o     <= 1'b1;
      ext_clk_periph_en_o <= 1'b1;
      periph_clk_en_o     <= 8'hFF;
    end else begin
      pin_change_en_o     <= 1'b1;
      ext_clk_periph_en_o <= 1'b1;
      unique case (next_state)
        psm_pkg::PSM_SLEEP: periph_clk_en_o <= 8'h00;
        psm_pkg::PSM_IDLE:  periph_clk_en_o <= ~pmd & ~sidl;
        default:            periph_clk_en_o <= ~pmd;
      endcase
    end
  end

  // AXI4-Lite write path: address and data accepted in either order
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (aw_hold && w_hold) begin
        aw_hold <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (aw_hold && w_hold) begin
        w_hold <= 1'b0;
      end
    end
  end

  // Readies drop while a transfer is held or its response waits
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_hold && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // Register writes and write response
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl         <= psm_pkg::CTRL_RESET;
      pmd          <= psm_pkg::PMD_RESET;
      sidl         <= psm_pkg::SIDL_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= psm_pkg::RESP_OKAY;
    end else begin
      if (aw_hold && w_hold) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= psm_pkg::RESP_OKAY;
        unique case (aw_addr)
          psm_pkg::CTRL_OFFSET: ctrl <= apply_strb(ctrl, w_data, w_strb) &
                                        CTRL_WRITABLE;
          psm_pkg::PMD_OFFSET:  pmd  <= 8'(apply_strb({24'h0, pmd}, w_data, w_strb));
          psm_pkg::SIDL_OFFSET: sidl <= 8'(apply_strb({24'h0, sidl}, w_data, w_strb));
          psm_pkg::STATUS_OFFSET: s_axi_bresp <= psm_pkg::RESP_OKAY;
          default: s_axi_bresp <= psm_pkg::RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read path
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= psm_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= psm_pkg::RESP_OKAY;
        unique case (s_axi_araddr)
          psm_pkg::CTRL_OFFSET:   s_axi_rdata <= ctrl;
          psm_pkg::STATUS_OFFSET: s_axi_rdata <= {22'h0, resume_clk_source_o,
                                                  4'h0, cpu_exec_o, low_power_rc_clock_en_o,
                                                  in_idle_o, in_sleep_o};
          psm_pkg::PMD_OFFSET:    s_axi_rdata <= {24'h0, pmd};
          psm_pkg::SIDL_OFFSET:   s_axi_rdata <= {24'h0, sidl};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= psm_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// *** bench/psm_core_model.sv ***
// Processor core model that issues power-save requests
`timescale 1ns/1ps
module psm_core_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [1:0] op_i,
  input  wire logic       cpu_exec_i,
  output logic            sleep_req_o,
  output logic            idle_req_o
);
  // Operand bit 0 asks Sleep, bit 1 asks Idle; held until the CPU stops
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sleep_req_o <= 1'b0;
      idle_req_o  <= 1'b0;
    end else if (op_i != 2'h0) begin
      sleep_req_o <= op_i[0];
      idle_req_o  <= op_i[1];
    end else if (!cpu_exec_i) begin
      sleep_req_o <= 1'b0;
      idle_req_o  <= 1'b0;
    end
  end
endmodule

// *** bench/psm_power_save_mode_control_asserts.sv ***
// Assertion checker for the power-save mode controller
`timescale 1ns/1ps
module psm_sva (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       irq_pending_i,
  input wire logic       wdt_timeout_i,
  input wire logic [1:0] clk_source_sel_i,
  input wire logic       sys_clk_en_o,
  input wire logic       osc_en_o,
  input wire logic       cpu_clk_en_o,
  input wire logic       cpu_exec_o,
  input wire logic       cfm_active_o,
  input wire logic       wdt_clear_o,
  input wire logic       pin_change_en_o,
  input wire logic       ext_clk_periph_en_o,
  input wire logic [1:0] resume_clk_source_o,
  input wire logic [7:0] periph_clk_en_o,
  input wire logic       in_sleep_o,
  input wire logic       in_idle_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_sleep_clk_off: assert property (in_sleep_o |-> !sys_clk_en_o && !osc_en_o)
    else $error("clock running in sleep");
  chk_sleep_cfm: assert property (in_sleep_o |-> !cfm_active_o)
    else $error("monitor active in sleep");
  chk_entry_clear: assert property (wdt_clear_o |->
    !cpu_exec_o ##1 (in_sleep_o || in_idle_o))
    else $error("watchdog clear not before entry");
  chk_sleep_periph: assert property (in_sleep_o |-> periph_clk_en_o == 8'h00)
    else $error("peripheral clocked in sleep");
  chk_pin_change: assert property (pin_change_en_o && ext_clk_periph_en_o)
    else $error("pin change logic stopped");
  chk_wake_event: assert property ((in_sleep_o || in_idle_o) &&
    (irq_pending_i || wdt_timeout_i) |=> !in_sleep_o && !in_idle_o)
    else $error("no wake on event");
  chk_resume_src: assert property ($rose(in_sleep_o) |->
    resume_clk_source_o == $past(clk_source_sel_i, 2))
    else $error("resume source not captured");
  chk_idle_cpu: assert property (in_idle_o |->
    sys_clk_en_o && !cpu_clk_en_o && !cpu_exec_o)
    else $error("idle gating wrong");
  chk_exec_delay: assert property ($rose(cpu_clk_en_o) |-> !cpu_exec_o [*3] ##1 cpu_exec_o)
    else $error("execution delay wrong");
endmodule

bind psm_power_save_mode_control psm_sva u_sva (.*);

// *** bench/test_power_save_mode_control.sv ***
// Testbench for the power-save mode controller
`timescale 1ns/1ps
module test_power_save_mode_control;
  logic clk_i, rst_n_i, sleep_req_i, idle_req_i, irq_pending_i, wdt_timeout_i;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic sys_clk_en_o, osc_en_o, cpu_clk_en_o, cpu_exec_o, cfm_active_o, low_power_rc_clock_en_o, wdt_clear_o;
  logic core_reg_standby_o, flash_reg_standby_o, pin_change_en_o, ext_clk_periph_en_o;
  logic in_sleep_o, in_idle_o, saw;
  logic [1:0] clk_source_sel_i, s_axi_bresp, s_axi_rresp, resume_clk_source_o, op, rsp;
  logic [7:0] s_axi_awaddr, s_axi_araddr, periph_clk_en_o;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  int errors, num_checks;
  psm_power_save_mode_control dut_u (.*);
  psm_core_model core_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .op_i(op), .cpu_exec_i(cpu_exec_o),
    .sleep_req_o(sleep_req_i), .idle_req_o(idle_req_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  // Issue the instruction; co pulses an interrupt in the entry cycle only
  task automatic enter(input logic [1:0] o, input logic co);
    int n;
    n = 0;
    saw = 1'b0;
    @(posedge clk_i);
    op <= o;
    @(posedge clk_i);
    op <= 2'h0;
    @(posedge clk_i);
    irq_pending_i <= co;
    do begin
      @(negedge clk_i);
      n++;
      saw = saw | wdt_clear_o;
      if (n == 1) begin
        @(posedge clk_i);
        irq_pending_i <= 1'b0;
      end
    end while (!(in_sleep_o || in_idle_o) && n < 20);
  endtask
  // Without drive the wake must come from an event already held
  task automatic wake(input logic w, input logic drive);
    int n;
    n = 0;
    if (drive) begin
      @(posedge clk_i);
      irq_pending_i <= !w;
      wdt_timeout_i <= w;
      @(posedge clk_i);
      irq_pending_i <= 1'b0;
      wdt_timeout_i <= 1'b0;
    end
    do begin
      @(negedge clk_i);
      n++;
    end while (!cpu_exec_o && n < 20);
    chk("wake_state", 32'h0, {in_sleep_o, in_idle_o});
    chk("wake_cycles", 32'h1, n inside {[3:5]});
  endtask
  task automatic t_regs;
    rdr(psm_pkg::CTRL_OFFSET);
    chk("ctrl_reset", psm_pkg::CTRL_RESET, rd);
    wr(psm_pkg::CTRL_OFFSET, 32'hFFFF_FFFF);
    rdr(psm_pkg::CTRL_OFFSET);
    chk("ctrl_bits", 32'h0000_0903, rd);
    wr(psm_pkg::STATUS_OFFSET, 32'hFFFF_FFFF);
    chk("status_wr_resp", psm_pkg::RESP_OKAY, rsp);
    rdr(psm_pkg::STATUS_OFFSET);
    chk("status", 32'h0000_000C, rd);
    rdr(8'h10);
    chk("unmapped", {30'h0, psm_pkg::RESP_SLVERR}, {rd[29:0], rsp});
    $display("test regs done");
  endtask
  task automatic t_sleep;
    for (int k = 0; k < 4; k++) begin
      wr(psm_pkg::CTRL_OFFSET, (k[1] ? 32'h800 : 32'h0) | (k[0] ? 32'h101 : 32'h0));
      clk_source_sel_i <= k[1:0];
      enter((k == 3) ? 2'h3 : 2'h1, 1'b0);
      chk("sleep", 32'h1, in_sleep_o);
      chk("wdt_clear", k[0], saw);
      chk("core_standby", !k[0], core_reg_standby_o);
      chk("flash_standby", !k[1], flash_reg_standby_o);
      chk("low_power_rc_clock_sleep", k[0], low_power_rc_clock_en_o);
      chk("gates", 32'h1, {sys_clk_en_o, osc_en_o, cfm_active_o,
          periph_clk_en_o, pin_change_en_o});
      clk_source_sel_i <= ~k[1:0];
      rdr(psm_pkg::STATUS_OFFSET);
      chk("resume_src", {k[1:0], 8'h01 | (k[0] ? 8'h04 : 8'h00)}, rd);
      wake(k[0], 1'b1);
    end
    $display("test sleep done");
  endtask
  task automatic t_idle;
    wr(psm_pkg::PMD_OFFSET, 32'h0F);
    wr(psm_pkg::SIDL_OFFSET, 32'h30);
    wr(psm_pkg::CTRL_OFFSET, 32'h2);
    enter(2'h2, 1'b0);
    chk("idle", 32'h1, in_idle_o);
    chk("no_clear", 32'h0, saw);
    chk("idle_periph", 32'hC0, periph_clk_en_o);
    chk("idle_misc", 32'h7, {low_power_rc_clock_en_o, sys_clk_en_o, cfm_active_o});
    wake(1'b1, 1'b1);
    chk("run_periph", 32'hF0, periph_clk_en_o);
    wr(psm_pkg::CTRL_OFFSET, 32'h1);
    enter(2'h2, 1'b1);
    chk("coincident", 32'h3, {saw, in_idle_o});
    wake(1'b0, 1'b0);
    $display("test idle done");
  endtask
  initial begin
    #100000;
    errors++;
    report_and_stop();
  end
  initial begin
    rst_n_i = 1'b0;
    {op, irq_pending_i, wdt_timeout_i, clk_source_sel_i} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    t_regs();
    t_sleep();
    t_idle();
    report_and_stop();
  end
endmodule
